// File: shared/ci_pkg.sv
// Constants, register map and types for the contour interpolator.
// Assumes a single 200 MHz clock and an APB register bus with 32-bit data.
package ci_pkg;
    localparam int NUM_AXES = 8;
    localparam int INC_W = 16;
    localparam int SUM_W = 24;
    localparam int POS_W = 32;
    localparam int EXP_W = 4;
    localparam int PT_W = 9;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IRQ_W = 4;

    // Segment exponent limits; zero is only legal as part of an exit record.
    localparam logic [EXP_W-1:0] EXP_EXIT = 4'h0;
    localparam logic [EXP_W-1:0] EXP_MIN = 4'h1;
    localparam logic [EXP_W-1:0] EXP_MAX = 4'h8;
    localparam logic signed [INC_W-1:0] INC_MAX = 16'sh7d00;
    localparam logic signed [INC_W-1:0] INC_MIN = 16'sh8300;

    // One interpolation point per millisecond.
    localparam int POINT_PERIOD_US = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_CYCLES = POINT_PERIOD_US * 1000 / CLK_PERIOD_NS;

    localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_EXP = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_COMMIT = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h00c;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 12'h010;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h014;
    localparam logic [ADDR_W-1:0] ADDR_REPLY = 12'h018;
    localparam logic [ADDR_W-1:0] ADDR_SEG_CNT = 12'h01c;
    localparam logic [6:0] PAGE_INC = 7'h01;
    localparam logic [6:0] PAGE_POS = 7'h02;

    localparam int ST_ACTIVE = 0;
    localparam int ST_RUNNING = 1;
    localparam int ST_PENDING = 2;
    localparam int ST_STALLED = 3;

    localparam int IRQ_SEG_DONE = 0;
    localparam int IRQ_ERROR = 1;
    localparam int IRQ_STALL = 2;
    localparam int IRQ_EXIT = 3;

    localparam logic [7:0] REPLY_ERR = 8'h3f;
    localparam logic [NUM_AXES-1:0] SEL_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;

    typedef enum logic [1:0] {
        CI_OFF = 2'b00,
        CI_STALL = 2'b01,
        CI_RUN = 2'b10
    } ci_state_t;
endpackage : ci_pkg

// File: shared/ci_axis_if.sv
// Link between the segment sequencer and one axis interpolator.
// Load and step coincide at a segment boundary; the axis takes the point first.
`timescale 1ns/1ps
interface ci_axis_if;
    logic load;
    logic step;
    logic [ci_pkg::EXP_W-1:0] exp;
    logic signed [ci_pkg::INC_W-1:0] inc;
    logic signed [ci_pkg::POS_W-1:0] pos;
    modport ctrl (output load, output step, output exp, output inc, input pos);
    modport axis (input load, input step, input exp, input inc, output pos);
endinterface : ci_axis_if

// File: verilog/ci_axis.sv
// One axis interpolator: spreads an increment linearly over 2^exp points.
// Assumes the sequencer pulses load once per segment and step once per point.
`timescale 1ns/1ps
module ci_axis (
    // Clock and reset.
    input logic pclk,
    input logic presetn,
    // Sequencer side.
    ci_axis_if.axis bus
);
    logic signed [ci_pkg::SUM_W-1:0] sum, next_sum;
    logic signed [ci_pkg::INC_W-1:0] inc_q, next_inc;
    logic [ci_pkg::EXP_W-1:0] exp_q, next_exp;
    logic signed [ci_pkg::POS_W-1:0] start, next_start, pos, next_pos;
    logic signed [ci_pkg::SUM_W-1:0] step_sum;
    logic signed [ci_pkg::POS_W-1:0] step_pos;

    assign bus.pos = pos;

    // The running sum is shifted, not a per-point step, so the remainder
    // is spread over the points and the last point lands exactly.
    assign step_sum = sum + ci_pkg::SUM_W'(inc_q);
    assign step_pos = start + ci_pkg::POS_W'(step_sum >>> exp_q);

    always_comb begin
        next_sum = sum;
        next_inc = inc_q;
        next_exp = exp_q;
        next_start = start;
        next_pos = pos;
        if (bus.step) begin
            next_sum = step_sum;
            next_pos = step_pos;
        end
        // A chained segment loads on the tick of the previous last point, so
        // that point is taken first and the new segment starts on target.
        if (bus.load) begin
            next_sum = '0;
            next_inc = bus.inc;
            next_exp = bus.exp;
            next_start = bus.step ? step_pos : pos;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum <= '0;
            inc_q <= '0;
            exp_q <= '0;
            start <= '0;
            pos <= '0;
        end else begin
            sum <= next_sum;
            inc_q <= next_inc;
            exp_q <= next_exp;
            start <= next_start;
            pos <= next_pos;
        end
    end

    property p_seg_exact;
        @(posedge pclk) disable iff (!presetn)
        bus.step && step_sum == (ci_pkg::SUM_W'(inc_q) <<< exp_q)
        |=> pos == $past(start) + ci_pkg::POS_W'($past(inc_q));
    endproperty
    a_seg_exact: assert property (p_seg_exact)
        else $error("segment end position differs from start plus increment");

    property p_load_restart;
        @(posedge pclk) disable iff (!presetn)
        bus.load |=> sum == 0 && start == pos && ($past(bus.step) || pos == $past(pos));
    endproperty
    a_load_restart: assert property (p_load_restart)
        else $error("segment load did not restart from current position");
endmodule : ci_axis

// File: verilog/ci_interp.sv
// Contour interpolator top: APB registers, record slot and segment sequencer.
// Assumes a single clock at 200 MHz; all bus inputs are on that clock.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

module ci_interp #(
    parameter int TICK_CYCLES = ci_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input logic pclk,
    input logic presetn,
    // APB slave.
    input logic [ci_pkg::ADDR_W-1:0] paddr,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [ci_pkg::DATA_W-1:0] pwdata,
    output logic pready,
    output logic [ci_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    // Motion outputs.
    output logic [ci_pkg::NUM_AXES-1:0] contour_active,
    output logic point_strobe,
    output logic [ci_pkg::NUM_AXES*ci_pkg::POS_W-1:0] axis_position,
    // Interrupt.
    output logic irq
);
    localparam int NA = ci_pkg::NUM_AXES;
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    ci_pkg::ci_state_t state, next_state;
    logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
    logic [ci_pkg::PT_W-1:0] pt_cnt, next_pt_cnt;
    logic [ci_pkg::EXP_W-1:0] cur_exp, next_cur_exp;
    logic [ci_pkg::NUM_AXES-1:0] axis_sel, next_axis_sel;
    logic [ci_pkg::EXP_W-1:0] exp_reg, next_exp_reg;
    logic signed [ci_pkg::INC_W-1:0] stage_inc [NA];
    logic signed [ci_pkg::INC_W-1:0] next_stage_inc [NA];
    logic signed [ci_pkg::INC_W-1:0] pend_inc [NA];
    logic signed [ci_pkg::INC_W-1:0] next_pend_inc [NA];
    logic pend_valid, next_pend_valid;
    logic pend_exit, next_pend_exit;
    logic [ci_pkg::EXP_W-1:0] pend_exp, next_pend_exp;
    logic [ci_pkg::DATA_W-1:0] seg_cnt, next_seg_cnt;
    logic [ci_pkg::IRQ_W-1:0] irq_stat, next_irq_stat;
    logic [ci_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;
    logic [ci_pkg::IRQ_W-1:0] irq_ev;
    logic [ci_pkg::DATA_W-1:0] next_prdata;
    logic next_pslverr;
    logic [ci_pkg::NUM_AXES-1:0] next_active;
    logic next_strobe;
    logic signed [ci_pkg::POS_W-1:0] pos_vec [NA];
    logic [ci_pkg::NUM_AXES-1:0] step_vec;

    logic wr_en, setup_rd, ms_tick, run_tick, last_pt, seg_end;
    logic take, load_seg, take_exit;
    logic ctrl_wr, ctrl_bad, commit_wr, commit_bad, accept;
    logic inc_bad, all_zero, exit_rec, exp_bad;
    logic [ci_pkg::PT_W-1:0] seg_len;
    logic [2:0] ridx;

    // Zero wait states: read data is fetched in the setup phase.
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign setup_rd = psel && !penable;
    assign ridx = paddr[4:2];
    assign ctrl_wr = wr_en && paddr == ci_pkg::ADDR_CTRL;
    assign commit_wr = wr_en && paddr == ci_pkg::ADDR_COMMIT;

    // Millisecond point tick, free running.
    assign ms_tick = tick_cnt == TICK_LAST;
    assign next_tick_cnt = ms_tick ? '0 : tick_cnt + TICK_W'(1);

    // Segment timing.
    assign seg_len = ci_pkg::PT_W'(1) << cur_exp;
    assign last_pt = pt_cnt == seg_len - ci_pkg::PT_W'(1);
    assign run_tick = ms_tick && state == ci_pkg::CI_RUN;
    assign seg_end = run_tick && last_pt;
    // The slot is drained only between segments, never mid-segment.
    assign take = pend_valid && (state == ci_pkg::CI_STALL || seg_end);
    assign load_seg = take && !pend_exit;
    assign take_exit = take && pend_exit;

    // Record checks on the staged values of the selected axes.
    always_comb begin
        inc_bad = 1'b0;
        all_zero = 1'b1;
        for (int i = 0; i < NA; i++) begin
            if (axis_sel[i]) begin
                if (stage_inc[i] > ci_pkg::INC_MAX || stage_inc[i] < ci_pkg::INC_MIN) begin
                    inc_bad = 1'b1;
                end
                if (stage_inc[i] != 0) begin
                    all_zero = 1'b0;
                end
            end
        end
    end

    assign exit_rec = exp_reg == ci_pkg::EXP_EXIT && all_zero;
    assign exp_bad = exp_reg > ci_pkg::EXP_MAX || (exp_reg == ci_pkg::EXP_EXIT && !all_zero);
    // A commit while the slot is full is refused rather than overwriting it.
    assign commit_bad = commit_wr
        && (state == ci_pkg::CI_OFF || pend_valid || inc_bad || exp_bad);
    assign accept = commit_wr && !commit_bad;
    // Changing the selection mid-contour would tear the path, so it is refused.
    assign ctrl_bad = ctrl_wr && state != ci_pkg::CI_OFF;

    // Sequencer state.
    always_comb begin
        next_state = state;
        case (state)
            ci_pkg::CI_OFF: begin
                if (ctrl_wr && pwdata[NA-1:0] != '0) begin
                    next_state = ci_pkg::CI_STALL;
                end
            end
            ci_pkg::CI_STALL: begin
                if (take_exit) begin
                    next_state = ci_pkg::CI_OFF;
                end else if (load_seg) begin
                    next_state = ci_pkg::CI_RUN;
                end
            end
            ci_pkg::CI_RUN: begin
                if (seg_end) begin
                    if (take_exit) begin
                        next_state = ci_pkg::CI_OFF;
                    end else if (!load_seg) begin
                        next_state = ci_pkg::CI_STALL;
                    end
                end
            end
            default: begin
                next_state = ci_pkg::CI_OFF;
            end
        endcase
    end

    // Point counter, exponent in use and segment count.
    always_comb begin
        next_pt_cnt = pt_cnt;
        next_cur_exp = cur_exp;
        if (load_seg) begin
            next_pt_cnt = '0;
            next_cur_exp = pend_exp;
        end else if (run_tick) begin
            next_pt_cnt = pt_cnt + ci_pkg::PT_W'(1);
        end
        // The count wraps silently so the path may run on without end.
        next_seg_cnt = seg_end ? seg_cnt + 32'h0000_0001 : seg_cnt;
        next_active = next_state == ci_pkg::CI_OFF ? '0 : next_axis_sel;
        next_strobe = run_tick;
    end

    // Software registers and the record slot.
    always_comb begin
        next_axis_sel = axis_sel;
        next_exp_reg = exp_reg;
        next_irq_mask = irq_mask;
        next_stage_inc = stage_inc;
        next_pend_inc = pend_inc;
        next_pend_exp = pend_exp;
        next_pend_exit = pend_exit;
        next_pend_valid = pend_valid;
        if (ctrl_wr && !ctrl_bad) begin
            next_axis_sel = pwdata[NA-1:0];
        end
        if (wr_en && paddr == ci_pkg::ADDR_EXP) begin
            next_exp_reg = pwdata[ci_pkg::EXP_W-1:0];
        end
        if (wr_en && paddr == ci_pkg::ADDR_IRQ_MASK) begin
            next_irq_mask = pwdata[ci_pkg::IRQ_W-1:0];
        end
        if (wr_en && paddr[11:5] == ci_pkg::PAGE_INC && paddr[1:0] == 2'h0) begin
            next_stage_inc[ridx] = pwdata[ci_pkg::INC_W-1:0];
        end
        if (accept) begin
            next_pend_valid = 1'b1;
            next_pend_inc = stage_inc;
            next_pend_exp = exp_reg;
            next_pend_exit = exit_rec;
        end else if (take) begin
            next_pend_valid = 1'b0;
        end
        if (take_exit) begin
            next_axis_sel = '0;
        end
    end

    // Sticky interrupt status; a new event wins over a write-one clear.
    always_comb begin
        irq_ev = '0;
        irq_ev[ci_pkg::IRQ_SEG_DONE] = seg_end;
        irq_ev[ci_pkg::IRQ_ERROR] = commit_bad || ctrl_bad;
        irq_ev[ci_pkg::IRQ_STALL] = seg_end && !pend_valid;
        irq_ev[ci_pkg::IRQ_EXIT] = take_exit;
        next_irq_stat = irq_stat;
        if (wr_en && paddr == ci_pkg::ADDR_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~pwdata[ci_pkg::IRQ_W-1:0];
        end
        next_irq_stat = next_irq_stat | irq_ev;
    end

    assign irq = |(irq_stat & irq_mask);

    // Read data and error answer, captured in the setup phase.
    always_comb begin
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (setup_rd) begin
            next_prdata = '0;
            case (paddr)
                ci_pkg::ADDR_CTRL: next_prdata[NA-1:0] = axis_sel;
                ci_pkg::ADDR_EXP: next_prdata[ci_pkg::EXP_W-1:0] = exp_reg;
                ci_pkg::ADDR_COMMIT: next_prdata = '0;
                ci_pkg::ADDR_STATUS: begin
                    next_prdata[ci_pkg::ST_ACTIVE] = state != ci_pkg::CI_OFF;
                    next_prdata[ci_pkg::ST_RUNNING] = state == ci_pkg::CI_RUN;
                    next_prdata[ci_pkg::ST_PENDING] = pend_valid;
                    next_prdata[ci_pkg::ST_STALLED] = state == ci_pkg::CI_STALL;
                end
                ci_pkg::ADDR_IRQ_STAT: next_prdata[ci_pkg::IRQ_W-1:0] = irq_stat;
                ci_pkg::ADDR_IRQ_MASK: next_prdata[ci_pkg::IRQ_W-1:0] = irq_mask;
                ci_pkg::ADDR_REPLY: begin
                    next_prdata[7:0] = irq_stat[ci_pkg::IRQ_ERROR] ? ci_pkg::REPLY_ERR : 8'h00;
                end
                ci_pkg::ADDR_SEG_CNT: next_prdata = seg_cnt;
                default: begin
                    if (paddr[1:0] != 2'h0) begin
                        next_pslverr = 1'b1;
                    end else if (paddr[11:5] == ci_pkg::PAGE_INC) begin
                        next_prdata = ci_pkg::DATA_W'(stage_inc[ridx]);
                    end else if (paddr[11:5] == ci_pkg::PAGE_POS) begin
                        next_prdata = pos_vec[ridx];
                    end else begin
                        next_pslverr = 1'b1;
                    end
                end
            endcase
        end else if (psel && penable) begin
            next_pslverr = pslverr;
        end
    end

    // Unmapped writes are caught in setup too, so pslverr stands in access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ci_pkg::CI_OFF;
            tick_cnt <= '0;
            pt_cnt <= '0;
            cur_exp <= ci_pkg::EXP_MIN;
            seg_cnt <= '0;
            contour_active <= '0;
            point_strobe <= 1'b0;
            axis_sel <= ci_pkg::SEL_RESET;
            exp_reg <= ci_pkg::EXP_EXIT;
            irq_mask <= ci_pkg::MASK_RESET;
            irq_stat <= '0;
            pend_valid <= 1'b0;
            pend_exit <= 1'b0;
            pend_exp <= ci_pkg::EXP_MIN;
            prdata <= '0;
            pslverr <= 1'b0;
            for (int i = 0; i < NA; i++) begin
                stage_inc[i] <= '0;
                pend_inc[i] <= '0;
            end
        end else begin
            state <= next_state;
            tick_cnt <= next_tick_cnt;
            pt_cnt <= next_pt_cnt;
            cur_exp <= next_cur_exp;
            seg_cnt <= next_seg_cnt;
            contour_active <= next_active;
            point_strobe <= next_strobe;
            axis_sel <= next_axis_sel;
            exp_reg <= next_exp_reg;
            irq_mask <= next_irq_mask;
            irq_stat <= next_irq_stat;
            pend_valid <= next_pend_valid;
            pend_exit <= next_pend_exit;
            pend_exp <= next_pend_exp;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            stage_inc <= next_stage_inc;
            pend_inc <= next_pend_inc;
        end
    end

    // One interpolator per axis; only selected axes load and step.
    for (genvar i = 0; i < NA; i++) begin : g_axis
        ci_axis_if ax ();
        assign ax.load = load_seg && axis_sel[i];
        assign ax.step = run_tick && axis_sel[i];
        assign ax.exp = pend_exp;
        assign ax.inc = pend_inc[i];
        assign pos_vec[i] = ax.pos;
        assign step_vec[i] = ax.step;
        assign axis_position[i*ci_pkg::POS_W +: ci_pkg::POS_W] = ax.pos;
        ci_axis u_axis (
            .pclk(pclk),
            .presetn(presetn),
            .bus(ax.axis)
        );
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_free_axes;
        (step_vec & ~contour_active) == '0;
    endproperty
    a_free_axes: assert property (p_free_axes)
        else $error("unselected axis was stepped");

    property p_exp_range;
        load_seg |=> cur_exp >= ci_pkg::EXP_MIN && cur_exp <= ci_pkg::EXP_MAX;
    endproperty
    a_exp_range: assert property (p_exp_range)
        else $error("segment started with illegal exponent");

    property p_point_rate;
        run_tick |=> point_strobe ##1 !point_strobe;
    endproperty
    a_point_rate: assert property (p_point_rate)
        else $error("point strobe not one cycle per tick");

    property p_range_check;
        commit_wr && inc_bad |-> commit_bad;
    endproperty
    a_range_check: assert property (p_range_check)
        else $error("out of range increment accepted");

    property p_exit;
        take_exit |=> state == ci_pkg::CI_OFF ##1 contour_active == '0;
    endproperty
    a_exit: assert property (p_exit)
        else $error("exit record did not leave contour mode");

    property p_keep_exp;
        accept |=> pend_exp == $past(exp_reg) && exp_reg == $past(exp_reg);
    endproperty
    a_keep_exp: assert property (p_keep_exp)
        else $error("retained exponent not used for record");

    property p_back_to_back;
        load_seg && state == ci_pkg::CI_RUN |-> last_pt && ms_tick;
    endproperty
    a_back_to_back: assert property (p_back_to_back)
        else $error("segment loaded before current one ended");

    property p_stall_quiet;
        state == ci_pkg::CI_STALL && !pend_valid |=> step_vec == '0 && !point_strobe;
    endproperty
    a_stall_quiet: assert property (p_stall_quiet)
        else $error("points emitted while stalled");

    property p_bad_reply;
        commit_bad |=> irq_stat[ci_pkg::IRQ_ERROR] && !$rose(pend_valid);
    endproperty
    a_bad_reply: assert property (p_bad_reply)
        else $error("bad record not flagged or was queued");

    property p_seg_count;
        seg_end |=> seg_cnt == $past(seg_cnt) + 32'h0000_0001;
    endproperty
    a_seg_count: assert property (p_seg_count)
        else $error("segment count did not advance");

    c_run: cover property (load_seg ##[1:1000] seg_end);
    c_chain: cover property (seg_end && load_seg);
    c_exit: cover property (take_exit);
    c_bad: cover property (commit_bad);
endmodule : ci_interp

// File: tb/ci_host_model.sv
// Host model: an APB master that feeds contour records to the interpolator.
// Assumes it shares pclk with the device and samples pready at rising edges.
`timescale 1ns/1ps
module ci_host_model (
    // Clock.
    input logic pclk,
    // APB master side.
    output logic [11:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input logic pready,
    input logic [31:0] prdata,
    input logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rdat, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines are scrambled so nothing can lean on stale values.
        paddr <= ~a;
        pwdata <= ~wd;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic e);
        xfer(1'b0, a, 32'h0, d, e);
    endtask : rd

    // The next record goes out only once the slot flag has dropped.
    task automatic wait_done();
        logic [31:0] s;
        logic e;
        do rd(12'h00c, s, e); while (s[ci_pkg::ST_PENDING] !== 1'b0);
    endtask : wait_done
endmodule : ci_host_model

// File: tb/contour_interpolator_tb_top.sv
// Self-checking bench for the contour interpolator, driven through the host model.
// Assumes a shortened tick of 20 cycles so segments finish quickly.
`timescale 1ns/1ps
module contour_interpolator_tb_top;
    localparam int TICK = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [7:0] contour_active;
    logic point_strobe;
    logic [255:0] axis_position;
    logic irq;
    logic [31:0] d;
    logic e;
    int miscompares = 0;
    int check_count = 0;
    int n;
    realtime tp = 0;
    logic [3:0] bad_e [3] = '{4'h9, 4'h2, 4'h0};
    logic [31:0] bad_i [3] = '{32'h1, 32'h7d01, 32'h5};

    always #2.5 pclk = ~pclk;

    ci_host_model host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
    ci_interp #(.TICK_CYCLES(TICK)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .contour_active(contour_active),
        .point_strobe(point_strobe), .axis_position(axis_position), .irq(irq));

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            miscompares++;
            $display("ERROR %0t got %h exp %h", $time, g, x);
        end
    endtask : chk

    task automatic end_sim();
        if (miscompares == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim

    // Floor division by a power of two, so negative increments round down.
    function automatic logic [31:0] pt(input int s, input int inc, input int k, input int ex);
        return 32'(s + ((inc * k) >>> ex));
    endfunction : pt

    task automatic seg_pts(input int s0, input int s2, input int i0, input int i2);
        for (int k = 1; k <= 4; k++) begin
            do @(negedge pclk); while (point_strobe !== 1'b1);
            if (tp != 0) chk(32'(int'($realtime - tp)), TICK * 5);
            tp = $realtime;
            chk(axis_position[31:0], pt(s0, i0, k, 2));
            chk(axis_position[95:64], pt(s2, i2, k, 2));
            chk(axis_position[63:32], 32'h0);
        end
    endtask : seg_pts

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        host.rd(12'h000, d, e);
        chk(d, 32'h0);
        host.rd(12'h00c, d, e);
        chk(d, 32'h0);
        host.rd(12'h100, d, e);
        chk({31'h0, e}, 32'h1);
        host.wr(12'h000, 32'h5);
        host.wr(12'h020, 32'd48);
        host.wr(12'h028, 32'hffff8300);
        host.wr(12'h004, 32'h2);
        @(negedge pclk);
        chk({24'h0, contour_active}, 32'h5);
        host.wr(12'h008, 32'h0);
        fork
            begin
                seg_pts(0, 0, 48, -32000);
                seg_pts(48, -32000, -5, 100);
            end
            begin
                host.wait_done();
                host.wr(12'h020, 32'hfffffffb);
                host.wr(12'h028, 32'd100);
                host.wr(12'h008, 32'h0);
            end
        join
        n = 0;
        repeat (3 * TICK) begin
            @(negedge pclk);
            if (point_strobe === 1'b1) n++;
        end
        chk(32'(n), 32'h0);
        host.rd(12'h00c, d, e);
        chk(d, 32'h9);
        host.rd(12'h01c, d, e);
        chk(d, 32'h2);
        host.rd(12'h040, d, e);
        chk(d, 32'd43);
        host.rd(12'h010, d, e);
        chk(d, 32'h5);
        chk({31'h0, irq}, 32'h0);
        host.wr(12'h014, 32'h4);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h1);
        host.wr(12'h010, 32'h5);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        for (int i = 0; i < 3; i++) begin
            host.wr(12'h004, {28'h0, bad_e[i]});
            host.wr(12'h020, bad_i[i]);
            host.wr(12'h008, 32'h0);
            host.rd(12'h018, d, e);
            chk(d, {24'h0, ci_pkg::REPLY_ERR});
            host.rd(12'h010, d, e);
            chk(d, 32'h2);
            host.wr(12'h010, 32'h2);
            host.rd(12'h018, d, e);
            chk(d, 32'h0);
        end
        host.wr(12'h000, 32'h2);
        host.rd(12'h000, d, e);
        chk(d, 32'h5);
        host.rd(12'h018, d, e);
        chk(d, {24'h0, ci_pkg::REPLY_ERR});
        host.wr(12'h010, 32'h2);
        host.wr(12'h004, 32'h0);
        host.wr(12'h020, 32'h0);
        host.wr(12'h028, 32'h0);
        host.wr(12'h008, 32'h0);
        repeat (3) @(negedge pclk);
        chk({24'h0, contour_active}, 32'h0);
        host.rd(12'h010, d, e);
        chk({31'h0, d[ci_pkg::IRQ_EXIT]}, 32'h1);
        host.rd(12'h000, d, e);
        chk(d, 32'h0);
        host.wr(12'h008, 32'h0);
        host.rd(12'h018, d, e);
        chk(d, {24'h0, ci_pkg::REPLY_ERR});
        end_sim();
    end

    initial begin
        repeat (6000) @(posedge pclk);
        miscompares++;
        end_sim();
    end
endmodule : contour_interpolator_tb_top
